// ==== bench/iapfw_chk.sv ====
// Port assertions of the flash programming front end.
`timescale 1ns/1ps
`include "iapfw_defs.svh"

module iapfw_chk (
  input wire logic        pclk,            // Clock.
  input wire logic        presetn,         // Reset, active low.
  input wire logic        psel,            // APB select.
  input wire logic        penable,         // APB access.
  input wire logic        pwrite,          // APB direction.
  input wire logic [11:0] paddr,           // APB address.
  input wire logic [31:0] pwdata,          // APB write data.
  input wire logic [31:0] prdata,          // APB read data.
  input wire logic        pready,          // APB ready.
  input wire logic        pslverr,         // APB error.
  input wire logic        flash_erase_req, // Erase running.
  input wire logic        flash_write_req, // Write running.
  input wire logic [7:0]  flash_page,      // Page in use.
  input wire logic        flash_done,      // Array finished.
  input wire logic [4:0]  buf_rd_index,    // Buffer index.
  input wire logic [15:0] buf_rd_data,     // Buffer word.
  input wire logic        erase_write_enabled // Unlocked.
);
  logic rd_ok; // A read completes at this edge.
  logic wr_ok; // A write takes effect at this edge.
  assign rd_ok = psel && penable && pready && !pwrite;
  assign wr_ok = psel && penable && pready && pwrite;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Status may only rise from the unlock logic, never from software.
  a_clear_upper: assert property (rd_ok && paddr == `IAPFW_OFF_CLR
    |-> prdata[31:1] == 31'h0) else $error("Clear register high bits set.");
  a_addr_high: assert property (rd_ok && paddr == `IAPFW_OFF_ADRH
    |-> prdata[31:5] == 27'h0) else $error("Address high top bits set.");
  a_en_no_set: assert property (wr_ok && paddr == `IAPFW_OFF_CTRL
    && !erase_write_enabled |=> !erase_write_enabled)
    else $error("Software set the enabled bit.");
  a_en_clear: assert property (wr_ok && paddr == `IAPFW_OFF_CTRL
    && !pwdata[7] |=> !erase_write_enabled)
    else $error("Enabled bit survived a clear.");
  a_req_unlocked: assert property ($rose(flash_erase_req ||
    flash_write_req) |-> $past(erase_write_enabled))
    else $error("Operation started while locked.");
  a_done_ends: assert property (flash_done && (flash_erase_req ||
    flash_write_req) |=> !flash_erase_req && !flash_write_req)
    else $error("Operation did not end on done.");
  a_one_op: assert property (!(flash_erase_req && flash_write_req))
    else $error("Erase and write at once.");
  a_page_held: assert property (flash_write_req && $past(flash_write_req)
    |-> $stable(flash_page)) else $error("Page moved during write.");
endmodule // iapfw_chk

bind iapfw_top iapfw_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flash_erase_req(flash_erase_req), .flash_write_req(flash_write_req),
  .flash_page(flash_page), .flash_done(flash_done),
  .buf_rd_index(buf_rd_index), .buf_rd_data(buf_rd_data),
  .erase_write_enabled(erase_write_enabled));

// ==== bench/iapfw_flash_model.sv ====
// Behavioural flash array serving page erase and page write.
`timescale 1ns/1ps

module iapfw_flash_model (
  input  wire logic        pclk,      // Clock.
  input  wire logic        erase_req, // Page erase request.
  input  wire logic        write_req, // Page write request.
  input  wire logic [7:0]  page,      // Page under operation.
  input  wire logic [15:0] rd_data,   // Buffer word, one cycle late.
  output logic             done,      // Pulse: operation over.
  output logic      [4:0]  rd_index   // Buffer word to fetch.
);
  logic [15:0] mem [0:8191]; // Page times 32 plus word offset.
  int          j;            // Word counter.

  // One operation at a time; a random latency covers quick and slow ends.
  initial begin
    done = 1'b0;
    rd_index = 5'h00;
    forever begin
      @(posedge pclk);
      if (erase_req === 1'b1 || write_req === 1'b1) begin
        for (j = 0; j < 32; j++) begin
          rd_index <= 5'(j);
          repeat (2) @(posedge pclk);
          mem[32 * page + j] = write_req ? rd_data : 16'h0000;
        end
        repeat ($urandom_range(9, 1)) @(posedge pclk);
        done <= 1'b1;
        @(posedge pclk);
        done <= 1'b0;
        // Wait for the request to drop so one operation is served once.
        while (erase_req === 1'b1 || write_req === 1'b1) @(posedge pclk);
      end
    end
  end
endmodule // iapfw_flash_model

// ==== bench/test_iap_flash_unlock_write_buffer.sv ====
// Self-checking bench of the flash programming front end.
`timescale 1ns/1ps

module test_iap_flash_unlock_write_buffer;
  logic        pclk, presetn, psel, penable, pwrite; // Clock, reset, APB.
  logic [11:0] paddr;                       // APB address.
  logic [31:0] pwdata, prdata, r;           // APB data, last read.
  logic        pready, pslverr, err;        // APB answer, last error.
  logic        erase_req, write_req, done, enabled; // Flash side.
  logic [7:0]  page, v, lo, hi;             // Page, random bytes.
  logic [4:0]  index;                       // Buffer index.
  logic [15:0] word;                        // Buffer word.
  logic [15:0] expw [32];                   // Expected page words.
  int          errors, checks, cyc, i, pg;  // Counters, loop, page.
  logic [7:0]  pat [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};

  iapfw_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_erase_req(erase_req), .flash_write_req(write_req),
    .flash_page(page), .flash_done(done), .buf_rd_index(index),
    .buf_rd_data(word), .erase_write_enabled(enabled));
  iapfw_flash_model flash (.pclk(pclk), .erase_req(erase_req),
    .write_req(write_req), .page(page), .rd_data(word), .done(done),
    .rd_index(index));

  always #10 pclk = ~pclk; // 50 MHz.

  // Hang guard: the whole run needs well under this many cycles.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input int a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 12'(a);
    pwdata <= {24'($urandom()), d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input int a, input logic [7:0] d); apb(1, a, d); endtask
  task automatic rd(input int a); apb(0, a, 8'h00); endtask
  task automatic seta(input int a); wr(8, a[7:0]); wr(12, a[12:8]); endtask

  // Start a page operation, poll the start bit, compare the page.
  task automatic op(input logic [7:0] c);
    wr(0, c);
    do rd(0); while (r[2] === 1'b1);
    chk(r[2], 1'b0);
    for (int j = 0; j < 32; j++) chk(flash.mem[32 * pg + j], expw[j]);
  endtask

  // Mode, trigger, then the six bytes; flip corrupts the third byte.
  task automatic unlock(input logic [7:0] m, input logic [7:0] flip);
    wr(0, m);
    wr(0, m | 8'h08);
    for (int j = 0; j < 6; j++) wr(24 + 4 * j, pat[j] ^ (j == 2 ? flip : 0));
    repeat (8) @(posedge pclk);
  endtask

  task automatic finish_test();
    $display("Checks %0d, errors %0d.", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    v = 8'($urandom(97595));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 12; i++) begin // Every register resets to zero.
      rd(4 * i);
      chk(r, 32'h0);
    end
    rd(48); // Unmapped address is refused.
    chk({r[30:0], err}, 32'h1);
    for (i = 2; i < 12; i++) begin // Address and data registers load while still locked.
      v = 8'($urandom());
      wr(4 * i, v);
      rd(4 * i);
      chk(r, (i == 3) ? {27'h0, v[4:0]} : {24'h0, v});
    end
    wr(4, 8'hFE);
    rd(4);
    chk(r, 32'h0);
    wr(0, 8'h80);
    rd(0);
    chk(r, 32'h0);
    unlock(8'h00, 8'h00); // Right bytes outside unlock mode.
    rd(0);
    chk(r, 32'h08);
    repeat (1030) @(posedge pclk);
    rd(0);
    chk(r, 32'h0);
    unlock(8'h60, 8'(1 << $urandom_range(7, 0)));
    repeat (1030) @(posedge pclk);
    rd(0);
    chk(r, 32'h60);
    unlock(8'hE0, 8'h00);
    rd(0);
    chk(r, 32'hE8);
    pg = $urandom_range(255, 0);
    expw = '{default: 16'h0};
    seta(32 * pg);
    op(8'h94);
    op(8'h84);
    seta(32 * pg + 30);
    for (i = 0; i < 3; i++) begin // Third word runs into the page end.
      {lo, hi} = 16'($urandom());
      wr(16, lo);
      rd(8);
      chk(r, 32'((32 * pg + 30 + (i > 0)) % 256));
      wr(20, hi);
      expw[i > 0 ? 31 : 30] = {hi, lo};
    end
    rd(12);
    chk(r, 32'((32 * pg + 31) / 256));
    op(8'h84);
    expw = '{default: 16'h0};
    wr(16, 8'h5A);
    wr(20, 8'hA5);
    wr(4, 8'h01);
    rd(4);
    chk(r, 32'h0);
    op(8'h84);
    wr(0, 8'h00);
    rd(0);
    chk(32'(enabled), 32'h0);
    repeat (1030) @(posedge pclk); // Let the unlock window close.
    wr(0, 8'h04);
    rd(0);
    chk(r, 32'h0);
    finish_test();
  end
endmodule // test_iap_flash_unlock_write_buffer

// ==== rtl/iapfw_defs.svh ====
// Constants of the flash programming front end: offsets, fields, timing.
`ifndef IAPFW_DEFS_SVH
`define IAPFW_DEFS_SVH

// ****************************************************************
// Register byte offsets on the APB window.
// ****************************************************************
`define IAPFW_OFF_CTRL   12'h000
`define IAPFW_OFF_CLR    12'h004
`define IAPFW_OFF_ADRL   12'h008
`define IAPFW_OFF_ADRH   12'h00C
`define IAPFW_OFF_D0L    12'h010
`define IAPFW_OFF_D0H    12'h014
`define IAPFW_OFF_D1L    12'h018
`define IAPFW_OFF_D1H    12'h01C
`define IAPFW_OFF_D2L    12'h020
`define IAPFW_OFF_D2H    12'h024
`define IAPFW_OFF_D3L    12'h028
`define IAPFW_OFF_D3H    12'h02C

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define IAPFW_EN_BIT     7
`define IAPFW_MODE_HI    6
`define IAPFW_MODE_LO    4
`define IAPFW_TRIG_BIT   3
`define IAPFW_START_BIT  2
`define IAPFW_RDEN_BIT   1
`define IAPFW_RD_BIT     0
`define IAPFW_CLR_BIT    0
`define IAPFW_RST_BYTE   8'h00
`define IAPFW_RST_ADDR   13'h0000
`define IAPFW_RST_WORD   16'h0000
`define IAPFW_PAGE_LAST  5'h1F

// ****************************************************************
// Operation mode codes.
// ****************************************************************
`define IAPFW_MODE_WRITE  3'b000
`define IAPFW_MODE_ERASE  3'b001
`define IAPFW_MODE_READ   3'b011
`define IAPFW_MODE_UNLOCK 3'b110

// ****************************************************************
// Unlock pattern, in register order word1 low .. word3 high.
// ****************************************************************
`define IAPFW_PAT_1L     8'h00
`define IAPFW_PAT_1H     8'h04
`define IAPFW_PAT_2L     8'h0D
`define IAPFW_PAT_2H     8'h09
`define IAPFW_PAT_3L     8'hC3
`define IAPFW_PAT_3H     8'h40

// ****************************************************************
// Unlock window length in pclk cycles.
// ****************************************************************
`define IAPFW_UNLOCK_CYC 11'd1024
`define IAPFW_CNT_ONE    11'd1

`endif

// ==== rtl/iapfw_pkg.sv ====
// Types shared by the flash programming front end.
package iapfw_pkg;

  // Register selected by an APB address.
  typedef enum {
    REG_CTRL, REG_CLR, REG_ADRL, REG_ADRH,
    REG_D0L, REG_D0H, REG_D1L, REG_D1H,
    REG_D2L, REG_D2H, REG_D3L, REG_D3H,
    REG_NONE
  } iapfw_reg_t;

  // Flash erase or write operation state.
  typedef enum {OP_IDLE, OP_ERASE, OP_WRITE} iapfw_op_t;

endpackage

// ==== rtl/iapfw_top.sv ====
// Flash programming front end: registers, write buffer and unlock.
`timescale 1ns/1ps
`include "iapfw_defs.svh"

module iapfw_top (
  input  wire logic        pclk,             // System clock, 50 MHz.
  input  wire logic        presetn,          // Async reset, active low.
  input  wire logic        psel,             // APB select.
  input  wire logic        penable,          // APB access phase.
  input  wire logic        pwrite,           // APB write when high.
  input  wire logic [11:0] paddr,            // APB byte address.
  input  wire logic [31:0] pwdata,           // APB write data.
  output logic      [31:0] prdata,           // APB read data.
  output logic             pready,           // APB transfer done.
  output logic             pslverr,          // APB unmapped address.
  output logic             flash_erase_req,  // Page erase in progress.
  output logic             flash_write_req,  // Page write in progress.
  output logic      [7:0]  flash_page,       // Page under operation.
  input  wire logic        flash_done,       // Pulse: array finished.
  input  wire logic [4:0]  buf_rd_index,     // Buffer word to read.
  output logic      [15:0] buf_rd_data,      // Buffer word, one cycle on.
  output logic             erase_write_enabled  // Unlocked status.
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [2:0]  operation_mode_field;  // Selected operation.
  logic        unlock_trigger;        // Unlock window requested.
  logic        write_start;           // Erase or write running.
  logic        read_enable;           // Read enable, stored only.
  logic        read_start;            // Read start, stored only.
  logic        buffer_clear_go;       // Buffer clear pending.
  logic [12:0] flash_address;         // Word address pair.
  logic [7:0]  data_low  [0:3];       // Low bytes of the four words.
  logic [7:0]  data_high [0:3];       // High bytes of the four words.
  logic [15:0] wbuf      [0:31];      // Page write buffer.
  iapfw_pkg::iapfw_op_t op_state;     // Array operation state.

  logic        setup;        // APB setup cycle.
  logic        wr_fire;      // APB write takes effect now.
  logic [31:0] next_prdata;  // Read value for the current address.
  logic        next_err;     // Current address is unmapped.
  iapfw_pkg::iapfw_reg_t wsel;  // Register under write.
  logic        load_word;    // Word0 high write reaches the buffer.
  logic        clear_all;    // Buffer wipe this cycle.
  logic        trig_pulse;   // Trigger bit written to 1.
  logic        start_ok;     // Start bit write accepted.
  logic [5:0]  pat_wr;       // Pattern byte write strobes.
  logic        unlock_exp;   // Window ended.
  logic        unlock_ok;    // Pattern accepted.

  // ****************************************************************
  // Address decode.
  // ****************************************************************

  // Shared by the read mux and the write path.
  function automatic iapfw_pkg::iapfw_reg_t reg_sel(
    input logic [11:0] a
  );
    case (a)
      `IAPFW_OFF_CTRL: reg_sel = iapfw_pkg::REG_CTRL;
      `IAPFW_OFF_CLR:  reg_sel = iapfw_pkg::REG_CLR;
      `IAPFW_OFF_ADRL: reg_sel = iapfw_pkg::REG_ADRL;
      `IAPFW_OFF_ADRH: reg_sel = iapfw_pkg::REG_ADRH;
      `IAPFW_OFF_D0L:  reg_sel = iapfw_pkg::REG_D0L;
      `IAPFW_OFF_D0H:  reg_sel = iapfw_pkg::REG_D0H;
      `IAPFW_OFF_D1L:  reg_sel = iapfw_pkg::REG_D1L;
      `IAPFW_OFF_D1H:  reg_sel = iapfw_pkg::REG_D1H;
      `IAPFW_OFF_D2L:  reg_sel = iapfw_pkg::REG_D2L;
      `IAPFW_OFF_D2H:  reg_sel = iapfw_pkg::REG_D2H;
      `IAPFW_OFF_D3L:  reg_sel = iapfw_pkg::REG_D3L;
      `IAPFW_OFF_D3H:  reg_sel = iapfw_pkg::REG_D3H;
      default:         reg_sel = iapfw_pkg::REG_NONE;
    endcase
  endfunction

  assign setup   = psel && !penable;
  assign wr_fire = psel && penable && pready && pwrite;
  assign wsel    = reg_sel(paddr);

  // ****************************************************************
  // Read mux.
  // ****************************************************************

  // Unimplemented bits are padded with zeros here.
  always_comb begin
    next_err    = 1'b0;
    next_prdata = 32'h0000_0000;
    case (reg_sel(paddr))
      iapfw_pkg::REG_CTRL: next_prdata[7:0] =
        {erase_write_enabled, operation_mode_field, unlock_trigger,
         write_start, read_enable, read_start};
      iapfw_pkg::REG_CLR:  next_prdata[0] = buffer_clear_go;
      iapfw_pkg::REG_ADRL: next_prdata[7:0] = flash_address[7:0];
      iapfw_pkg::REG_ADRH: next_prdata[4:0] = flash_address[12:8];
      iapfw_pkg::REG_D0L:  next_prdata[7:0] = data_low[0];
      iapfw_pkg::REG_D0H:  next_prdata[7:0] = data_high[0];
      iapfw_pkg::REG_D1L:  next_prdata[7:0] = data_low[1];
      iapfw_pkg::REG_D1H:  next_prdata[7:0] = data_high[1];
      iapfw_pkg::REG_D2L:  next_prdata[7:0] = data_low[2];
      iapfw_pkg::REG_D2H:  next_prdata[7:0] = data_high[2];
      iapfw_pkg::REG_D3L:  next_prdata[7:0] = data_low[3];
      iapfw_pkg::REG_D3H:  next_prdata[7:0] = data_high[3];
      default:             next_err = 1'b1;
    endcase
  end

  // ****************************************************************
  // APB answer.
  // ****************************************************************

  // One wait-free access phase: data and error are captured in the
  // setup cycle and presented with pready in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= setup ? next_prdata : 32'h0000_0000;
      pslverr <= setup && next_err;
    end
  end

  // ****************************************************************
  // Main control register.
  // ****************************************************************

  assign trig_pulse = wr_fire && wsel == iapfw_pkg::REG_CTRL &&
                      pwdata[`IAPFW_TRIG_BIT];
  assign start_ok   = wr_fire && wsel == iapfw_pkg::REG_CTRL &&
                      pwdata[`IAPFW_START_BIT] && erase_write_enabled &&
                      op_state == iapfw_pkg::OP_IDLE &&
                      (operation_mode_field == `IAPFW_MODE_WRITE ||
                       operation_mode_field == `IAPFW_MODE_ERASE);

  // Mode and read bits are plain storage; the read path lies outside.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operation_mode_field <= 3'b000;
      read_enable          <= 1'b0;
      read_start           <= 1'b0;
    end else if (wr_fire && wsel == iapfw_pkg::REG_CTRL) begin
      operation_mode_field <= pwdata[`IAPFW_MODE_HI:`IAPFW_MODE_LO];
      read_enable          <= pwdata[`IAPFW_RDEN_BIT];
      read_start           <= pwdata[`IAPFW_RD_BIT];
    end
  end

  // The hardware grant wins over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_write_enabled <= 1'b0;
    end else if (unlock_ok) begin
      erase_write_enabled <= 1'b1;
    end else if (wr_fire && wsel == iapfw_pkg::REG_CTRL &&
                 !pwdata[`IAPFW_EN_BIT]) begin
      erase_write_enabled <= 1'b0;
    end
  end

  // Software sets the trigger; only the window's end clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_trigger <= 1'b0;
    end else if (trig_pulse) begin
      unlock_trigger <= 1'b1;
    end else if (unlock_exp) begin
      unlock_trigger <= 1'b0;
    end
  end

  // ****************************************************************
  // Erase and write operation.
  // ****************************************************************

  // A start is refused unless unlocked, idle and in erase or write
  // mode. Once running it finishes even if the status bit drops,
  // since stopping the array half way would corrupt the page.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_state        <= iapfw_pkg::OP_IDLE;
      write_start     <= 1'b0;
      flash_erase_req <= 1'b0;
      flash_write_req <= 1'b0;
      flash_page      <= 8'h00;
    end else begin
      case (op_state)
        iapfw_pkg::OP_IDLE: begin
          if (start_ok) begin
            write_start <= 1'b1;
            flash_page  <= flash_address[12:5];
            if (operation_mode_field == `IAPFW_MODE_ERASE) begin
              op_state        <= iapfw_pkg::OP_ERASE;
              flash_erase_req <= 1'b1;
            end else begin
              op_state        <= iapfw_pkg::OP_WRITE;
              flash_write_req <= 1'b1;
            end
          end
        end
        iapfw_pkg::OP_ERASE,
        iapfw_pkg::OP_WRITE: begin
          if (flash_done) begin
            op_state        <= iapfw_pkg::OP_IDLE;
            write_start     <= 1'b0;
            flash_erase_req <= 1'b0;
            flash_write_req <= 1'b0;
          end
        end
        default: begin
          op_state <= iapfw_pkg::OP_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Buffer clear control.
  // ****************************************************************

  // The clear takes one cycle, so the bit reads 1 for a single cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_clear_go <= 1'b0;
    end else if (wr_fire && wsel == iapfw_pkg::REG_CLR &&
                 pwdata[`IAPFW_CLR_BIT]) begin
      buffer_clear_go <= 1'b1;
    end else begin
      buffer_clear_go <= 1'b0;
    end
  end

  // A finished page write also empties the buffer.
  assign clear_all = buffer_clear_go ||
                     (op_state == iapfw_pkg::OP_WRITE && flash_done);

  // ****************************************************************
  // Address pair.
  // ****************************************************************

  assign load_word = wr_fire && wsel == iapfw_pkg::REG_D0H &&
                     erase_write_enabled;

  // The increment stays inside the page so a long burst cannot spill
  // into the neighbouring page.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_address <= `IAPFW_RST_ADDR;
    end else if (wr_fire && wsel == iapfw_pkg::REG_ADRL) begin
      flash_address[7:0] <= pwdata[7:0];
    end else if (wr_fire && wsel == iapfw_pkg::REG_ADRH) begin
      flash_address[12:8] <= pwdata[4:0];
    end else if (load_word &&
                 flash_address[4:0] != `IAPFW_PAGE_LAST) begin
      flash_address <= flash_address + 13'd1;
    end
  end

  // ****************************************************************
  // Data registers.
  // ****************************************************************

  // Each word pair decodes at a fixed stride of two registers.
  genvar gw;
  generate
    for (gw = 0; gw < 4; gw++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          data_low[gw]  <= `IAPFW_RST_BYTE;
          data_high[gw] <= `IAPFW_RST_BYTE;
        end else if (wr_fire && wsel ==
                     iapfw_pkg::iapfw_reg_t'(4 + 2 * gw)) begin
          data_low[gw] <= pwdata[7:0];
        end else if (wr_fire && wsel ==
                     iapfw_pkg::iapfw_reg_t'(5 + 2 * gw)) begin
          data_high[gw] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Write buffer.
  // ****************************************************************

  // The loaded word takes the high byte straight from the bus, since
  // the high register updates in the same cycle.
  genvar gb;
  generate
    for (gb = 0; gb < 32; gb++) begin : g_buf
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wbuf[gb] <= `IAPFW_RST_WORD;
        end else if (clear_all) begin
          wbuf[gb] <= `IAPFW_RST_WORD;
        end else if (load_word && flash_address[4:0] == 5'(gb)) begin
          wbuf[gb] <= {pwdata[7:0], data_low[0]};
        end
      end
    end
  endgenerate

  // Array-side read port, one cycle of latency.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_rd_data <= `IAPFW_RST_WORD;
    end else begin
      buf_rd_data <= wbuf[buf_rd_index];
    end
  end

  // ****************************************************************
  // Unlock.
  // ****************************************************************

  assign pat_wr = {wr_fire && wsel == iapfw_pkg::REG_D3H,
                   wr_fire && wsel == iapfw_pkg::REG_D3L,
                   wr_fire && wsel == iapfw_pkg::REG_D2H,
                   wr_fire && wsel == iapfw_pkg::REG_D2L,
                   wr_fire && wsel == iapfw_pkg::REG_D1H,
                   wr_fire && wsel == iapfw_pkg::REG_D1L};

  iapfw_unlock u_unlock (
    .pclk    (pclk),
    .presetn (presetn),
    .trigger (trig_pulse),
    .mode_ok (operation_mode_field == `IAPFW_MODE_UNLOCK),
    .byte_wr (pat_wr),
    .pattern ({data_high[3], data_low[3], data_high[2], data_low[2],
               data_high[1], data_low[1]}),
    .expire  (unlock_exp),
    .grant   (unlock_ok)
  );

endmodule // iapfw_top

// ==== rtl/iapfw_unlock.sv ====
// Unlock window timer and pattern checker.
`timescale 1ns/1ps
`include "iapfw_defs.svh"

module iapfw_unlock (
  input  wire logic        pclk,      // System clock.
  input  wire logic        presetn,   // Asynchronous reset, active low.
  input  wire logic        trigger,   // Pulse: trigger bit written to 1.
  input  wire logic        mode_ok,   // Unlock mode is selected.
  input  wire logic [5:0]  byte_wr,   // Pulses: pattern byte written.
  input  wire logic [47:0] pattern,   // Six pattern bytes, 1L lowest.
  output logic             expire,    // Pulse: window ended.
  output logic             grant      // Pulse: correct pattern seen.
);

  logic        running;  // Window open.
  logic [10:0] count;    // Cycles since the window opened.
  logic [5:0]  seen;     // Pattern bytes written in this window.

  // ****************************************************************
  // Window timer.
  // ****************************************************************

  // A new trigger restarts the window, even on its last cycle, so the
  // trigger bit can never be left high without a running timer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
      count   <= 11'd0;
      expire  <= 1'b0;
    end else if (trigger) begin
      running <= 1'b1;
      count   <= 11'd0;
      expire  <= 1'b0;
    end else if (running &&
                 count == `IAPFW_UNLOCK_CYC - `IAPFW_CNT_ONE) begin
      running <= 1'b0;
      expire  <= 1'b1;
    end else begin
      count  <= running ? count + `IAPFW_CNT_ONE : count;
      expire <= 1'b0;
    end
  end

  // ****************************************************************
  // Pattern check.
  // ****************************************************************

  // Bytes count only inside the window and in unlock mode; a wrong
  // byte simply never matches, so the grant does not come.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen  <= 6'h00;
      grant <= 1'b0;
    end else if (trigger || !running) begin
      seen  <= 6'h00;
      grant <= 1'b0;
    end else if (mode_ok && seen == 6'h3F &&
                 pattern == {`IAPFW_PAT_3H, `IAPFW_PAT_3L,
                             `IAPFW_PAT_2H, `IAPFW_PAT_2L,
                             `IAPFW_PAT_1H, `IAPFW_PAT_1L}) begin
      grant <= 1'b1;
      seen  <= 6'h00;
    end else begin
      seen  <= mode_ok ? (seen | byte_wr) : seen;
      grant <= 1'b0;
    end
  end

endmodule // iapfw_unlock
